// ===== ppb_params.svh
`ifndef PPB_PARAMS_SVH
`define PPB_PARAMS_SVH

`define PPB_ADR_CTRL 6'h00
`define PPB_ADR_PEN 6'h04
`define PPB_ADR_STAT 6'h08
`define PPB_ADR_PAD 6'h0C
`define PPB_ADR_OUT1 6'h10
`define PPB_ADR_OUT2 6'h14
`define PPB_ADR_IN1 6'h18
`define PPB_ADR_IN2 6'h1C
`define PPB_ADR_IST 6'h20
`define PPB_ADR_IMSK 6'h24

`define PPB_PEN_MASK 16'h47FF
`define PPB_PAD_MASK 16'h0007
`define PPB_CTRL_MASK 16'h003F
`define PPB_CTRL_EN 0
`define PPB_CTRL_MODE 2:1
`define PPB_CTRL_IRQM 4:3
`define PPB_CTRL_BUFD 5
`define PPB_ST_IBF 15
`define PPB_ST_INPUT_OVERFLOW_FLAG 14
`define PPB_ST_OBE 7
`define PPB_ST_OUTPUT_UNDERFLOW_FLAG 6
`define PPB_EV_ACC 0
`define PPB_EV_OV 1
`define PPB_EV_UF 2
`define PPB_EMPTY_RST 4'hF
`define PPB_IRQM_END 2'h1
`define PPB_IRQM_SLOT3 2'h3
`endif

// ===== ppb_pkg.sv
package ppb_pkg;
    typedef enum logic [1:0] {
        PPB_LEGACY,
        PPB_ADDRESSABLE,
        PPB_MASTER2,
        PPB_MASTER1
    } ppb_mode_t;

    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic [1:0] addr;
        logic [7:0] data;
    } ppb_host_in_t;

    typedef struct packed {
        logic chip_select_pad;
        logic [8:0] upper_address_pads;
        logic [1:0] low_address_pads;
    } ppb_pad_func_t;
endpackage

// ===== ppb_top.sv
`timescale 1ns/1ns
`include "ppb_params.svh"
module ppb_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire ppb_pkg::ppb_host_in_t host_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe,
    output ppb_pkg::ppb_pad_func_t pad_func_o,
    output logic [2:0] pad_config_o,
    output logic irq_o
);
    import ppb_pkg::*;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] slot_dec(input logic [1:0] idx);
        slot_dec = 4'h1 << idx;
    endfunction

    function automatic logic [7:0] slot_byte(input logic [31:0] w,
                                             input logic [1:0] idx);
        slot_byte = w[idx*8 +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [15:0] ctrl_ff;
    logic [15:0] pen_ff;
    logic [15:0] pad_ff;
    logic [31:0] ob_ff;
    logic [31:0] ib_ff;
    logic [3:0] ib_full_ff;
    logic [3:0] ob_empty_ff;
    logic input_overflow_flag_ff;
    logic output_underflow_flag_ff;
    logic [2:0] ist_ff;
    logic [2:0] imsk_ff;
    logic rd_q_ff;
    logic wr_q_ff;
    logic [1:0] ptr_ff;
    logic [7:0] hdo_ff;
    logic [15:0] stat;
    logic req, wr_en, rd_en;
    logic slave_mode, mod_en;
    logic h_rd, h_wr, h_acc;
    logic [1:0] slot;
    logic [3:0] h_sel;
    logic [3:0] sw_ob_wr, sw_ib_rd;
    logic set_ov, set_uf, set_acc;
    ppb_mode_t mode;

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the strobe, dropped after
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_en = req & wb_we_i & ack_ff;
    assign rd_en = req & ~wb_we_i & ack_ff;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    always_comb begin
        stat = 16'h0000;
        stat[`PPB_ST_IBF] = &ib_full_ff;
        stat[`PPB_ST_INPUT_OVERFLOW_FLAG] = input_overflow_flag_ff;
        stat[11:8] = ib_full_ff;
        stat[`PPB_ST_OBE] = &ob_empty_ff;
        stat[`PPB_ST_OUTPUT_UNDERFLOW_FLAG] = output_underflow_flag_ff;
        stat[3:0] = ob_empty_ff;
    end

    // Read data is latched on the first cycle so it holds under ack
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_ff <= 32'h0000_0000;
        end else if (req & ~ack_ff) begin
            unique case (wb_adr_i)
                `PPB_ADR_CTRL: dat_ff <= {16'h0000, ctrl_ff};
                `PPB_ADR_PEN: dat_ff <= {16'h0000, pen_ff};
                `PPB_ADR_STAT: dat_ff <= {16'h0000, stat};
                `PPB_ADR_PAD: dat_ff <= {16'h0000, pad_ff};
                `PPB_ADR_OUT1: dat_ff <= {16'h0000, ob_ff[15:0]};
                `PPB_ADR_OUT2: dat_ff <= {16'h0000, ob_ff[31:16]};
                `PPB_ADR_IN1: dat_ff <= {16'h0000, ib_ff[15:0]};
                `PPB_ADR_IN2: dat_ff <= {16'h0000, ib_ff[31:16]};
                `PPB_ADR_IST: dat_ff <= {29'h0000_0000, ist_ff};
                `PPB_ADR_IMSK: dat_ff <= {29'h0000_0000, imsk_ff};
                default: dat_ff <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= 16'h0000;
            pen_ff <= 16'h0000;
            pad_ff <= 16'h0000;
            imsk_ff <= 3'h0;
        end else if (wr_en & wb_sel_i[0]) begin
            unique case (wb_adr_i)
                `PPB_ADR_CTRL: ctrl_ff <= wb_dat_i[15:0] & `PPB_CTRL_MASK;
                `PPB_ADR_PEN: pen_ff <= wb_dat_i[15:0] & `PPB_PEN_MASK;
                `PPB_ADR_PAD: pad_ff <= wb_dat_i[15:0] & `PPB_PAD_MASK;
                `PPB_ADR_IMSK: imsk_ff <= wb_dat_i[2:0];
                default: ;
            endcase
        end
    end

    assign pad_func_o.chip_select_pad = pen_ff[14];
    assign pad_func_o.upper_address_pads = pen_ff[10:2];
    assign pad_func_o.low_address_pads = pen_ff[1:0];
    assign pad_config_o = pad_ff[2:0];

    ////////////////////////////////////////////////////////////////////
    // Host side: strobe rising edges mark one access each
    assign mode = ppb_mode_t'(ctrl_ff[`PPB_CTRL_MODE]);
    assign mod_en = ctrl_ff[`PPB_CTRL_EN];
    always_comb begin
        unique case (mode)
            PPB_LEGACY: slave_mode = 1'b1;
            PPB_ADDRESSABLE: slave_mode = 1'b1;
            PPB_MASTER2: slave_mode = 1'b0;
            PPB_MASTER1: slave_mode = 1'b0;
        endcase
    end

    // Module disabled: no pin driven, no access taken
    assign h_rd = mod_en & slave_mode & host_i.cs & host_i.rd & ~rd_q_ff;
    assign h_wr = mod_en & slave_mode & host_i.cs & host_i.wr & ~wr_q_ff;
    assign h_acc = h_rd | h_wr;
    // Legacy port uses slot 0 unless buffered stepping is on
    assign slot = (mode == PPB_ADDRESSABLE) ? host_i.addr :
                  (ctrl_ff[`PPB_CTRL_BUFD] ? ptr_ff : 2'h0);
    assign h_sel = slot_dec(slot);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q_ff <= 1'b0;
            wr_q_ff <= 1'b0;
            ptr_ff <= 2'h0;
        end else begin
            rd_q_ff <= host_i.cs & host_i.rd;
            wr_q_ff <= host_i.cs & host_i.wr;
            if (h_acc & (mode == PPB_LEGACY) & ctrl_ff[`PPB_CTRL_BUFD]) begin
                ptr_ff <= ptr_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hdo_ff <= 8'h00;
        end else if (h_rd) begin
            hdo_ff <= slot_byte(ob_ff, slot);
        end
    end
    assign host_data_o = hdo_ff;
    assign host_data_oe = mod_en & slave_mode & host_i.cs & host_i.rd;

    ////////////////////////////////////////////////////////////////////
    // Buffer storage and per-slot flags
    assign sw_ob_wr[0] = wr_en & (wb_adr_i == `PPB_ADR_OUT1) & wb_sel_i[0];
    assign sw_ob_wr[1] = wr_en & (wb_adr_i == `PPB_ADR_OUT1) & wb_sel_i[1];
    assign sw_ob_wr[2] = wr_en & (wb_adr_i == `PPB_ADR_OUT2) & wb_sel_i[0];
    assign sw_ob_wr[3] = wr_en & (wb_adr_i == `PPB_ADR_OUT2) & wb_sel_i[1];
    assign sw_ib_rd[0] = rd_en & (wb_adr_i == `PPB_ADR_IN1) & wb_sel_i[0];
    assign sw_ib_rd[1] = rd_en & (wb_adr_i == `PPB_ADR_IN1) & wb_sel_i[1];
    assign sw_ib_rd[2] = rd_en & (wb_adr_i == `PPB_ADR_IN2) & wb_sel_i[0];
    assign sw_ib_rd[3] = rd_en & (wb_adr_i == `PPB_ADR_IN2) & wb_sel_i[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ob_ff <= 32'h0000_0000;
            ib_ff <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (sw_ob_wr[i]) begin
                    ob_ff[i*8 +: 8] <= wb_dat_i[(i%2)*8 +: 8];
                end
                // Overflowing writes are dropped; unread data survives
                if (h_wr & h_sel[i] & ~ib_full_ff[i]) begin
                    ib_ff[i*8 +: 8] <= host_i.data;
                end
            end
        end
    end

    // Host fill wins over a software drain in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ib_full_ff <= 4'h0;
        end else begin
            ib_full_ff <= (ib_full_ff & ~sw_ib_rd) |
                          ({4{h_wr}} & h_sel);
        end
    end

    // Fresh software data wins over a host drain of the old byte
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ob_empty_ff <= `PPB_EMPTY_RST;
        end else begin
            ob_empty_ff <= (ob_empty_ff | ({4{h_rd}} & h_sel)) &
                           ~sw_ob_wr;
        end
    end

    assign set_ov = h_wr & |(h_sel & ib_full_ff);
    assign set_uf = h_rd & |(h_sel & ob_empty_ff);

    // Error flags clear by writing zero; a new event wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_overflow_flag_ff <= 1'b0;
            output_underflow_flag_ff <= 1'b0;
        end else begin
            input_overflow_flag_ff <= set_ov | (input_overflow_flag_ff & ~(wr_en &
                (wb_adr_i == `PPB_ADR_STAT) & wb_sel_i[1] &
                ~wb_dat_i[`PPB_ST_INPUT_OVERFLOW_FLAG]));
            output_underflow_flag_ff <= set_uf | (output_underflow_flag_ff & ~(wr_en &
                (wb_adr_i == `PPB_ADR_STAT) & wb_sel_i[0] &
                ~wb_dat_i[`PPB_ST_OUTPUT_UNDERFLOW_FLAG]));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupts: sticky, write one to clear, set wins
    always_comb begin
        unique case (ctrl_ff[`PPB_CTRL_IRQM])
            `PPB_IRQM_END: set_acc = h_acc;
            `PPB_IRQM_SLOT3: set_acc = h_acc & (slot == 2'h3);
            default: set_acc = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ist_ff <= 3'h0;
        end else begin
            ist_ff <= (ist_ff & ~({3{wr_en & wb_sel_i[0] &
                       (wb_adr_i == `PPB_ADR_IST)}} & wb_dat_i[2:0])) |
                      {set_uf, set_ov, set_acc};
        end
    end
    assign irq_o = |(ist_ff & imsk_ff);

    ////////////////////////////////////////////////////////////////////
    chk_all_full: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stat[`PPB_ST_IBF] == (ib_full_ff == 4'hF))
        else $error("all-full summary wrong");
    chk_all_empty: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stat[`PPB_ST_OBE] == (ob_empty_ff == 4'hF))
        else $error("all-empty summary wrong");
    chk_ovf_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        h_wr & |(h_sel & ib_full_ff) |=> input_overflow_flag_ff & ist_ff[`PPB_EV_OV])
        else $error("overflow not flagged");
    chk_ovf_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        input_overflow_flag_ff & ~wr_en |=> input_overflow_flag_ff)
        else $error("overflow lost without write");
    chk_unf_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        h_rd & |(h_sel & ob_empty_ff) |=> output_underflow_flag_ff)
        else $error("underflow not flagged");
    chk_full_fill: assert property (@(posedge ref_clk) disable iff (!rst_n)
        h_wr & ~ib_full_ff[slot] |=> ib_full_ff[$past(slot)] &&
        ib_ff[$past(slot)*8 +: 8] == $past(host_i.data))
        else $error("input slot not filled");
    chk_empty_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sw_ob_wr[0] |=> ~ob_empty_ff[0] ##0 ~stat[`PPB_ST_OBE])
        else $error("output slot still empty");
    chk_pen_resv: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pen_ff & ~`PPB_PEN_MASK) == 16'h0000)
        else $error("reserved pin enable bit set");
    chk_no_access: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ~mod_en |-> ~host_data_oe & ~h_acc)
        else $error("access while disabled");
    chk_slot3_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        h_acc & (mode == PPB_ADDRESSABLE) & (host_i.addr == 2'h3) &
        (ctrl_ff[`PPB_CTRL_IRQM] == `PPB_IRQM_SLOT3) |=> ist_ff[`PPB_EV_ACC])
        else $error("slot 3 interrupt missing");
    chk_host_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        h_rd |=> host_data_o == slot_byte($past(ob_ff), $past(slot)))
        else $error("host read data wrong");

    cov_overflow: cover property (@(posedge ref_clk) disable iff (!rst_n)
        set_ov);
    cov_underflow: cover property (@(posedge ref_clk) disable iff (!rst_n)
        set_uf);
    cov_all_full: cover property (@(posedge ref_clk) disable iff (!rst_n)
        stat[`PPB_ST_IBF] ##[1:50] sw_ib_rd[3]);
    cov_irq: cover property (@(posedge ref_clk) disable iff (!rst_n)
        irq_o);
endmodule

// ===== ppb_host_model.sv
`timescale 1ns/1ns
module ppb_host_model (
    input wire logic ref_clk,
    output ppb_pkg::ppb_host_in_t host_bus
);
    import ppb_pkg::*;

    initial host_bus = '0;

    // Strobe high for two edges, then low: each call is one access
    task automatic access(input logic we, input logic [1:0] a,
                          input logic [7:0] d);
        @(posedge ref_clk);
        host_bus.cs <= 1'b1;
        host_bus.rd <= ~we;
        host_bus.wr <= we;
        host_bus.addr <= a;
        host_bus.data <= we ? d : ~host_bus.data;
        repeat (2) @(posedge ref_clk);
        host_bus.cs <= 1'b0;
        host_bus.rd <= 1'b0;
        host_bus.wr <= 1'b0;
        // Released data line shows no stale value
        host_bus.data <= ~host_bus.data;
        @(posedge ref_clk);
    endtask
endmodule

// ===== test_parallel_port_buffer_status.sv
`timescale 1ns/1ns
`include "ppb_params.svh"
module test_parallel_port_buffer_status;
    import ppb_pkg::*;
    logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] host_data_o;
    logic host_data_oe, irq_o;
    logic [2:0] pad_config_o;
    ppb_host_in_t host_i;
    ppb_pad_func_t pad_func_o;
    int err_count, tests_run, oe_n;
    logic [31:0] wb_q[$], host_q[$];
    logic [7:0] ob[4], ib[4];
    logic [15:0] r;
    logic [3:0] sel_v;
    logic [31:0] cv[3] = '{32'h0000_0002, 32'h0000_0005, 32'h0000_0007};

    ppb_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .host_i(host_i), .host_data_o(host_data_o),
        .host_data_oe(host_data_oe), .pad_func_o(pad_func_o),
        .pad_config_o(pad_config_o), .irq_o(irq_o));
    ppb_host_model i_host (.ref_clk(ref_clk), .host_bus(host_i));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waits for ack as long as it takes; only the watchdog ends a hang
    task automatic wb(input logic we, input logic [5:0] a,
                      input logic [31:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel_v;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        wb_q.push_back(exp);
        wb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic final_report;
        $display("Checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Unexpected result pops nothing and compares against unknown
    always @(posedge ref_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            check("wb_dat_o", wb_dat_o,
                  wb_q.size() ? wb_q.pop_front() : 'x);
        end
        oe_n = (host_data_oe === 1'b1) ? oe_n + 1 : 0;
        if (oe_n == 2) begin
            check("host_data_o", {24'h0, host_data_o},
                  host_q.size() ? host_q.pop_front() : 'x);
        end
    end

    initial begin
        #40000;
        err_count++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        wb_adr_i = 6'h00;
        wb_sel_i = 4'hF;
        sel_v = 4'hF;
        wb_dat_i = 32'h0000_0000;
        err_count = 0;
        tests_run = 0;
        oe_n = 0;
        r = 16'($urandom(66));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`PPB_ADR_STAT, 32'h0000_008F);
        wr(`PPB_ADR_PEN, 32'h0000_FFFF);
        rd(`PPB_ADR_PEN, 32'h0000_47FF);
        r = 16'($urandom());
        wr(`PPB_ADR_PEN, {16'h0, r});
        rd(`PPB_ADR_PEN, {16'h0, r & 16'h47FF});
        #1 check("pad_func_o", 32'(pad_func_o),
                 {20'h0, r[14], r[10:2], r[1:0]});
        wr(`PPB_ADR_PAD, {16'h0, r});
        rd(`PPB_ADR_PAD, {29'h0, r[2:0]});
        #1 check("pad_config_o", {29'h0, pad_config_o}, {29'h0, r[2:0]});
        rd(6'h30, 32'h0000_0000);
        // Addressable slave, interrupt on slot 3
        wr(`PPB_ADR_CTRL, 32'h0000_001B);
        wr(`PPB_ADR_IMSK, 32'h0000_0007);
        for (int i = 0; i < 4; i++) ob[i] = 8'($urandom());
        wr(`PPB_ADR_OUT1, {16'h0, ob[1], ob[0]});
        wr(`PPB_ADR_OUT2, {16'h0, ob[3], ob[2]});
        rd(`PPB_ADR_STAT, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            host_q.push_back({24'h0, ob[i]});
            i_host.access(1'b0, 2'(i), 8'h00);
            #1 check("irq_o", {31'h0, irq_o}, {31'h0, i == 3});
        end
        rd(`PPB_ADR_STAT, 32'h0000_008F);
        host_q.push_back({24'h0, ob[3]});
        i_host.access(1'b0, 2'd3, 8'h00);
        rd(`PPB_ADR_STAT, 32'h0000_00CF);
        rd(`PPB_ADR_IST, 32'h0000_0005);
        wr(`PPB_ADR_IMSK, 32'h0000_0000);
        #1 check("irq_o", {31'h0, irq_o}, 32'h0);
        wr(`PPB_ADR_IST, 32'h0000_0007);
        rd(`PPB_ADR_IST, 32'h0000_0000);
        wr(`PPB_ADR_IMSK, 32'h0000_0007);
        wr(`PPB_ADR_STAT, 32'h0000_0000);
        rd(`PPB_ADR_STAT, 32'h0000_008F);
        for (int i = 0; i < 4; i++) begin
            ib[i] = 8'($urandom());
            i_host.access(1'b1, 2'(i), ib[i]);
        end
        rd(`PPB_ADR_STAT, 32'h0000_8F8F);
        i_host.access(1'b1, 2'd2, ~ib[2]);
        rd(`PPB_ADR_STAT, 32'h0000_CF8F);
        rd(`PPB_ADR_IN1, {16'h0, ib[1], ib[0]});
        rd(`PPB_ADR_STAT, 32'h0000_4C8F);
        rd(`PPB_ADR_IN2, {16'h0, ib[3], ib[2]});
        wr(`PPB_ADR_STAT, 32'h0000_0000);
        rd(`PPB_ADR_STAT, 32'h0000_008F);
        // Disabled and master personalities must leave the host ignored
        for (int k = 0; k < 3; k++) begin
            wr(`PPB_ADR_CTRL, cv[k]);
            i_host.access(1'b1, 2'd1, 8'hA5);
            i_host.access(1'b0, 2'd1, 8'h00);
            rd(`PPB_ADR_STAT, 32'h0000_008F);
        end
        // Legacy slave ignores the address lines
        wr(`PPB_ADR_CTRL, 32'h0000_0001);
        wr(`PPB_ADR_OUT1, {16'h0, ob[1], ob[0]});
        host_q.push_back({24'h0, ob[0]});
        i_host.access(1'b0, 2'd3, 8'h00);
        i_host.access(1'b1, 2'd3, ib[3]);
        rd(`PPB_ADR_STAT, 32'h0000_010D);
        // Buffered legacy stepping walks slots 0 to 3
        rd(`PPB_ADR_IN1, {16'h0, ib[1], ib[3]});
        wr(`PPB_ADR_IST, 32'h0000_0007);
        wr(`PPB_ADR_CTRL, 32'h0000_0039);
        for (int i = 0; i < 4; i++) begin
            ib[i] = 8'($urandom());
            i_host.access(1'b1, 2'd0, ib[i]);
            #1 check("irq_o", {31'h0, irq_o}, {31'h0, i == 3});
        end
        rd(`PPB_ADR_IN1, {16'h0, ib[1], ib[0]});
        rd(`PPB_ADR_IN2, {16'h0, ib[3], ib[2]});
        // Interrupt on the strobe rising edge of every access, slot 0 here
        wr(`PPB_ADR_IST, 32'h0000_0007);
        wr(`PPB_ADR_CTRL, 32'h0000_0029);
        i_host.access(1'b1, 2'd3, 8'h5A);
        rd(`PPB_ADR_IST, 32'h0000_0001);
        // Byte lane write touches slot 3 only
        sel_v = 4'h2;
        wr(`PPB_ADR_OUT2, 32'h0000_C33C);
        sel_v = 4'hF;
        rd(`PPB_ADR_OUT2, {16'h0, 8'hC3, ob[2]});
        rd(`PPB_ADR_STAT, 32'h0000_0105);
        repeat (4) @(posedge ref_clk);
        final_report();
    end
endmodule
